// ==== pcfo_regs.svh ====
// register map and timing constants of the counter-array frequency output block
// assumes a byte-wide register port with 8-bit offsets
`ifndef PCFO_REGS_SVH
`define PCFO_REGS_SVH

// ==========================================
// documented compare byte offsets
`define PCFO_CMP0_LO 8'hfb
`define PCFO_CMP0_HI 8'hfc
`define PCFO_CMP1_LO 8'he9
`define PCFO_CMP1_HI 8'hea
`define PCFO_CMP2_LO 8'heb
`define PCFO_CMP2_HI 8'hec
`define PCFO_CMP3_LO 8'hed
`define PCFO_CMP3_HI 8'hee
`define PCFO_CMP4_LO 8'hfd
`define PCFO_CMP4_HI 8'hfe
`define PCFO_CMP5_LO 8'hd2
`define PCFO_CMP5_HI 8'hd3

// ==========================================
// added control and status offsets
`define PCFO_CHMODE_BASE 8'hc0
`define PCFO_CTRMODE 8'hc8
`define PCFO_PULSECFG 8'hc9
`define PCFO_IRQ_STATUS 8'hca
`define PCFO_IRQ_MASK 8'hcb
`define PCFO_CTR_LO 8'hcc
`define PCFO_CTR_HI 8'hcd
`define PCFO_CHMODE0 8'hc0
`define PCFO_CHMODE1 8'hc1
`define PCFO_CHMODE2 8'hc2
`define PCFO_CHMODE3 8'hc3
`define PCFO_CHMODE4 8'hc4
`define PCFO_CHMODE5 8'hc5
`define PCFO_NO_SEL 3'h7

// ==========================================
// field positions
`define PCFO_MODE_CMP_EN 6
`define PCFO_MODE_MATCH_EN 3
`define PCFO_MODE_TOG_EN 2
`define PCFO_MODE_PULSE_EN 1
`define PCFO_CTR_RUN 0
`define PCFO_CPS_LSB 1
`define PCFO_RELOAD_SEL 7

// ==========================================
// clock sources and reset values
`define PCFO_CPS_DIV12 3'h0
`define PCFO_CPS_DIV4 3'h1
`define PCFO_CPS_EXT 3'h2
`define PCFO_CPS_SYS 3'h3
`define PCFO_DIV12_LAST 4'hb
`define PCFO_DIV4_LAST 4'h3
`define PCFO_RST_BYTE 8'h00
`define PCFO_RST_WORD 16'h0000
`define PCFO_NCH 6

`endif

// ==== pcfo_pkg.sv ====
// types shared by the frequency output block
// assumes pcfo_regs.svh alongside
package pcfo_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pcfo_bus_t;

    typedef struct packed {
        logic cmp_en;
        logic match_en;
        logic tog_en;
        logic pulse_en;
    } pcfo_mode_t;
endpackage

// ==== pcfo_top.sv ====
// six-channel counter array compare block with square wave outputs
// assumes a byte register port and an external counter clock input
`include "pcfo_regs.svh"
`timescale 1ns/100ps

module pcfo_top
    import pcfo_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // counter clock source, synchronous pulse per external tick
    input wire logic ext_tick,
    // outputs
    output logic [5:0] channel_output_pin,
    output logic irq
);
    // ==========================================
    // state
    pcfo_bus_t bus;
    pcfo_mode_t mode_reg [0:5];
    logic [15:0] cmp_reg [0:5];
    logic [15:0] reload_reg [0:5];
    logic [15:0] ctr_reg;
    logic [3:0] pre_reg;
    logic [2:0] cps_reg;
    logic run_reg;
    logic reload_sel_reg;
    logic [5:0] flag_reg;
    logic [5:0] mask_reg;
    logic [5:0] pin_reg;
    logic tick;
    logic [2:0] wsel;
    logic wlo;
    logic whi;
    logic [7:0] mode_byte [0:5];
    logic [7:0] rdata_next;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign channel_output_pin = pin_reg;

    // byte address to channel and half decode
    always_comb begin
        wsel = `PCFO_NO_SEL;
        wlo = 1'b0;
        whi = 1'b0;
        case (bus.addr)
            `PCFO_CMP0_LO: begin
                wsel = 3'h0;
                wlo = 1'b1;
            end
            `PCFO_CMP0_HI: begin
                wsel = 3'h0;
                whi = 1'b1;
            end
            `PCFO_CMP1_LO: begin
                wsel = 3'h1;
                wlo = 1'b1;
            end
            `PCFO_CMP1_HI: begin
                wsel = 3'h1;
                whi = 1'b1;
            end
            `PCFO_CMP2_LO: begin
                wsel = 3'h2;
                wlo = 1'b1;
            end
            `PCFO_CMP2_HI: begin
                wsel = 3'h2;
                whi = 1'b1;
            end
            `PCFO_CMP3_LO: begin
                wsel = 3'h3;
                wlo = 1'b1;
            end
            `PCFO_CMP3_HI: begin
                wsel = 3'h3;
                whi = 1'b1;
            end
            `PCFO_CMP4_LO: begin
                wsel = 3'h4;
                wlo = 1'b1;
            end
            `PCFO_CMP4_HI: begin
                wsel = 3'h4;
                whi = 1'b1;
            end
            `PCFO_CMP5_LO: begin
                wsel = 3'h5;
                wlo = 1'b1;
            end
            `PCFO_CMP5_HI: begin
                wsel = 3'h5;
                whi = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // ==========================================
    // counter clock selection
    always_comb begin
        case (cps_reg)
            `PCFO_CPS_DIV12: tick = (pre_reg == `PCFO_DIV12_LAST);
            `PCFO_CPS_DIV4: tick = (pre_reg[1:0] == `PCFO_DIV4_LAST);
            `PCFO_CPS_EXT: tick = ext_tick;
            `PCFO_CPS_SYS: tick = 1'b1;
            default: tick = 1'b1;
        endcase
        tick = tick & run_reg;
    end

    always_ff @(posedge clk) begin
        if (reset || pre_reg == `PCFO_DIV12_LAST || !run_reg) begin
            pre_reg <= 4'h0;
        end else begin
            pre_reg <= pre_reg + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctr_reg <= `PCFO_RST_WORD;
        end else if (bus.wr && bus.addr == `PCFO_CTR_LO) begin
            ctr_reg[7:0] <= bus.wdata;
        end else if (bus.wr && bus.addr == `PCFO_CTR_HI) begin
            ctr_reg[15:8] <= bus.wdata;
        end else if (tick) begin
            ctr_reg <= ctr_reg + 16'h0001;
        end
    end

    // ==========================================
    // global control registers
    // counter stopped out of reset so software sets it up first
    always_ff @(posedge clk) begin
        if (reset) begin
            cps_reg <= 3'h0;
            run_reg <= 1'b0;
        end else if (bus.wr && bus.addr == `PCFO_CTRMODE) begin
            cps_reg <= bus.wdata[`PCFO_CPS_LSB +: 3];
            run_reg <= bus.wdata[`PCFO_CTR_RUN];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reload_sel_reg <= 1'b0;
        end else if (bus.wr && bus.addr == `PCFO_PULSECFG) begin
            reload_sel_reg <= bus.wdata[`PCFO_RELOAD_SEL];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mask_reg <= 6'h00;
        end else if (bus.wr && bus.addr == `PCFO_IRQ_MASK) begin
            mask_reg <= bus.wdata[5:0];
        end
    end

    // ==========================================
    // per-channel compare logic
    genvar g;
    generate
        for (g = 0; g < `PCFO_NCH; g++) begin : gch
            logic freq_mode;
            logic lo_match;
            logic full_match;
            logic sel_lo;
            logic sel_hi;
            logic [7:0] step;
            assign freq_mode = mode_reg[g].cmp_en & mode_reg[g].tog_en
                & mode_reg[g].pulse_en;
            // compare disabled blocks every match effect
            assign lo_match = tick && freq_mode && (cmp_reg[g][7:0] == ctr_reg[7:0]);
            assign full_match = tick && mode_reg[g].cmp_en && mode_reg[g].match_en
                && (cmp_reg[g] == ctr_reg);
            assign sel_lo = bus.wr && wlo && wsel == 3'(g);
            assign sel_hi = bus.wr && whi && wsel == 3'(g);
            // 8-bit add wraps so a zero step spans 256 counter ticks
            assign step = cmp_reg[g][7:0] + cmp_reg[g][15:8];
            assign mode_byte[g] = {1'b0, mode_reg[g].cmp_en, 2'b00, mode_reg[g].match_en,
                mode_reg[g].tog_en, mode_reg[g].pulse_en, 1'b0};

            // a software write beats the re-arm add in the same cycle
            always_ff @(posedge clk) begin
                if (reset) begin
                    cmp_reg[g] <= `PCFO_RST_WORD;
                end else if (sel_lo && !reload_sel_reg) begin
                    cmp_reg[g][7:0] <= bus.wdata;
                end else if (sel_hi && !reload_sel_reg) begin
                    cmp_reg[g][15:8] <= bus.wdata;
                end else if (lo_match) begin
                    cmp_reg[g][7:0] <= step;
                end
            end

            // reload bytes are stored only; no pulse width modes here
            always_ff @(posedge clk) begin
                if (reset) begin
                    reload_reg[g] <= `PCFO_RST_WORD;
                end else if (sel_lo && reload_sel_reg) begin
                    reload_reg[g][7:0] <= bus.wdata;
                end else if (sel_hi && reload_sel_reg) begin
                    reload_reg[g][15:8] <= bus.wdata;
                end
            end

            always_ff @(posedge clk) begin
                if (reset) begin
                    mode_reg[g] <= '0;
                end else if (bus.wr && bus.addr == `PCFO_CHMODE_BASE + 8'(g)) begin
                    mode_reg[g].cmp_en <= bus.wdata[`PCFO_MODE_CMP_EN];
                    mode_reg[g].match_en <= bus.wdata[`PCFO_MODE_MATCH_EN];
                    mode_reg[g].tog_en <= bus.wdata[`PCFO_MODE_TOG_EN];
                    mode_reg[g].pulse_en <= bus.wdata[`PCFO_MODE_PULSE_EN];
                end else if (sel_lo) begin
                    mode_reg[g].cmp_en <= 1'b0;
                end else if (sel_hi) begin
                    mode_reg[g].cmp_en <= 1'b1;
                end
            end

            always_ff @(posedge clk) begin
                if (reset) begin
                    pin_reg[g] <= 1'b0;
                end else if (lo_match) begin
                    pin_reg[g] <= ~pin_reg[g];
                end
            end

            // set wins over a write-one clear in the same cycle
            always_ff @(posedge clk) begin
                if (reset) begin
                    flag_reg[g] <= 1'b0;
                end else if (full_match) begin
                    flag_reg[g] <= 1'b1;
                end else if (bus.wr && bus.addr == `PCFO_IRQ_STATUS && bus.wdata[g]) begin
                    flag_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================
    // interrupt output, registered
    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flag_reg & mask_reg);
        end
    end

    // ==========================================
    // read mux; unmapped addresses read as zero
    always_comb begin
        rdata_next = `PCFO_RST_BYTE;
        case (bus.addr)
            `PCFO_CMP0_LO: begin
                rdata_next = reload_sel_reg ? reload_reg[0][7:0] : cmp_reg[0][7:0];
            end
            `PCFO_CMP0_HI: begin
                rdata_next = reload_sel_reg ? reload_reg[0][15:8] : cmp_reg[0][15:8];
            end
            `PCFO_CMP1_LO: begin
                rdata_next = reload_sel_reg ? reload_reg[1][7:0] : cmp_reg[1][7:0];
            end
            `PCFO_CMP1_HI: begin
                rdata_next = reload_sel_reg ? reload_reg[1][15:8] : cmp_reg[1][15:8];
            end
            `PCFO_CMP2_LO: begin
                rdata_next = reload_sel_reg ? reload_reg[2][7:0] : cmp_reg[2][7:0];
            end
            `PCFO_CMP2_HI: begin
                rdata_next = reload_sel_reg ? reload_reg[2][15:8] : cmp_reg[2][15:8];
            end
            `PCFO_CMP3_LO: begin
                rdata_next = reload_sel_reg ? reload_reg[3][7:0] : cmp_reg[3][7:0];
            end
            `PCFO_CMP3_HI: begin
                rdata_next = reload_sel_reg ? reload_reg[3][15:8] : cmp_reg[3][15:8];
            end
            `PCFO_CMP4_LO: begin
                rdata_next = reload_sel_reg ? reload_reg[4][7:0] : cmp_reg[4][7:0];
            end
            `PCFO_CMP4_HI: begin
                rdata_next = reload_sel_reg ? reload_reg[4][15:8] : cmp_reg[4][15:8];
            end
            `PCFO_CMP5_LO: begin
                rdata_next = reload_sel_reg ? reload_reg[5][7:0] : cmp_reg[5][7:0];
            end
            `PCFO_CMP5_HI: begin
                rdata_next = reload_sel_reg ? reload_reg[5][15:8] : cmp_reg[5][15:8];
            end
            `PCFO_CHMODE0: begin
                rdata_next = mode_byte[0];
            end
            `PCFO_CHMODE1: begin
                rdata_next = mode_byte[1];
            end
            `PCFO_CHMODE2: begin
                rdata_next = mode_byte[2];
            end
            `PCFO_CHMODE3: begin
                rdata_next = mode_byte[3];
            end
            `PCFO_CHMODE4: begin
                rdata_next = mode_byte[4];
            end
            `PCFO_CHMODE5: begin
                rdata_next = mode_byte[5];
            end
            `PCFO_CTRMODE: begin
                rdata_next = {4'h0, cps_reg, run_reg};
            end
            `PCFO_PULSECFG: begin
                rdata_next = {reload_sel_reg, 7'h00};
            end
            `PCFO_IRQ_STATUS: begin
                rdata_next = {2'b00, flag_reg};
            end
            `PCFO_IRQ_MASK: begin
                rdata_next = {2'b00, mask_reg};
            end
            `PCFO_CTR_LO: begin
                rdata_next = ctr_reg[7:0];
            end
            `PCFO_CTR_HI: begin
                rdata_next = ctr_reg[15:8];
            end
            default: begin
                rdata_next = `PCFO_RST_BYTE;
            end
        endcase
    end

    // read data stands one cycle after the strobe, zero otherwise
    // no read side effects, so a stray read never disturbs a channel
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= `PCFO_RST_BYTE;
        end else if (bus.rd) begin
            rdata <= rdata_next;
        end else begin
            rdata <= `PCFO_RST_BYTE;
        end
    end
endmodule

// ==== pcfo_props.sv ====
// port checker of the frequency output block, bound to its top module
// assumes the register map header and the offsets chosen for channel 0
`include "pcfo_regs.svh"
`timescale 1ns/100ps
module pcfo_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // counter source and outputs
    input wire logic ext_tick,
    input wire logic [5:0] channel_output_pin,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================
    // register port
    rd_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data outside a read cycle");
    unmapped_zero_a: assert property (rd && addr == 8'h00 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    byte_readback_a: assert property (wr && addr == `PCFO_CMP0_HI
        ##1 rd && addr == `PCFO_CMP0_HI |=> rdata == $past(wdata, 2))
        else $error("high byte read back differs");
    low_clears_en_a: assert property (wr && addr == `PCFO_CMP0_LO
        ##1 rd && addr == `PCFO_CHMODE_BASE |=> !rdata[`PCFO_MODE_CMP_EN])
        else $error("low byte write left compare enabled");
    high_sets_en_a: assert property (wr && addr == `PCFO_CMP0_HI
        ##1 rd && addr == `PCFO_CHMODE_BASE |=> rdata[`PCFO_MODE_CMP_EN])
        else $error("high byte write left compare disabled");
    // ==========================================
    // outputs
    held_when_off_a: assert property ((wr && addr == `PCFO_CMP0_LO)
        ##1 (!wr) [*6] |-> $stable(channel_output_pin[0]))
        else $error("pin moved with compare disabled");
    irq_masked_off_a: assert property (wr && addr == `PCFO_IRQ_MASK
        && wdata == 8'h00 |-> ##2 !irq)
        else $error("interrupt high with all masked");
    reset_idle_a: assert property ($fell(reset) |-> !irq && channel_output_pin == 6'h00)
        else $error("outputs not idle after reset");
endmodule

bind pcfo_top pcfo_props u_pcfo_props (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_tick(ext_tick),
    .channel_output_pin(channel_output_pin), .irq(irq));

// ==== pcfo_load.sv ====
// load on one square wave output: times its half period and counts edges
// assumes the pin is a registered level in the clk domain
`timescale 1ns/100ps
module pcfo_load (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // driven pin
    input wire logic pin,
    // measurements
    output logic [9:0] half,
    output logic [15:0] edges
);
    logic pin_reg;
    logic [9:0] run_reg;
    // half holds the clocks between the last two edges
    always_ff @(posedge clk) begin
        pin_reg <= pin;
        run_reg <= (pin != pin_reg) ? 10'h001 : run_reg + 10'h001;
        if (pin != pin_reg) begin
            half <= run_reg;
            edges <= edges + 16'h0001;
        end
        if (reset) begin
            half <= 10'h000;
            edges <= 16'h0000;
        end
    end
endmodule

// ==== pcfo_top_test.sv ====
// self-checking bench of the frequency output block
// assumes the design, the checker and the load model compiled first
`include "pcfo_regs.svh"
`timescale 1ns/100ps
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin n_fail++; \
    $display("wrong value at %0t: %h not %h", $time, (g), (w)); end end
module pcfo_top_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ext_tick = 1'b0;
    logic [7:0] rdata;
    logic [5:0] channel_output_pin;
    logic irq;
    logic [9:0] half;
    logic [15:0] edges;
    logic [15:0] e;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    localparam logic [7:0] OFFS[12] = '{`PCFO_CMP0_LO, `PCFO_CMP0_HI, `PCFO_CMP1_LO,
        `PCFO_CMP1_HI, `PCFO_CMP2_LO, `PCFO_CMP2_HI, `PCFO_CMP3_LO, `PCFO_CMP3_HI,
        `PCFO_CMP4_LO, `PCFO_CMP4_HI, `PCFO_CMP5_LO, `PCFO_CMP5_HI};
    // half periods for high byte 4 under clock select 0..3 (ext tick every 3)
    localparam logic [9:0] HEXP[4] = '{10'h030, 10'h010, 10'h00c, 10'h004};
    localparam logic [7:0] OFFMODE[3] = '{8'h44, 8'h42, 8'h06};

    pcfo_top u_pcfo_top (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ext_tick(ext_tick),
        .channel_output_pin(channel_output_pin), .irq(irq));
    pcfo_load u_pcfo_load (.clk(clk), .reset(reset), .pin(channel_output_pin[0]),
        .half(half), .edges(edges));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        ext_tick <= (cyc % 3 == 0);
        if (cyc == 32'h0000_9c40) begin
            n_fail++;
            results();
        end
    end
    // ==========================================
    // register port tasks; drives change at a rising edge, checks at the falling one
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        rd <= 1'b0;
    endtask
    task automatic check(input logic [7:0] a, input logic [7:0] want);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(rdata, want)
    endtask
    task automatic settle(input int n);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n - 1) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // tests
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 12; i++) check(OFFS[i], 8'h00);
        check(8'h00, 8'h00);
        wr_reg(`PCFO_PULSECFG, 8'h80);
        wr_reg(`PCFO_CMP0_LO, 8'h5a);
        wr_reg(`PCFO_CMP0_HI, 8'ha5);
        check(`PCFO_CMP0_HI, 8'ha5);
        check(`PCFO_CMP0_LO, 8'h5a);
        wr_reg(`PCFO_PULSECFG, 8'h00);
        check(`PCFO_CMP0_LO, 8'h00);
        check(`PCFO_CMP0_HI, 8'h00);
        wr_reg(`PCFO_CHMODE_BASE, 8'h46);
        wr_reg(`PCFO_CMP0_LO, 8'h10);
        check(`PCFO_CHMODE_BASE, 8'h06);
        wr_reg(`PCFO_CMP0_HI, 8'h04);
        check(`PCFO_CHMODE_BASE, 8'h46);
        for (int c = 0; c < 4; c++) begin
            wr_reg(`PCFO_CTRMODE, 8'((c << 1) | 1));
            settle(HEXP[c] * 16'h0044);
            `CHK(half, HEXP[c])
        end
        wr_reg(`PCFO_CMP0_HI, 8'h00);
        settle(16'h0320);
        `CHK(half, 10'h100)
        check(`PCFO_IRQ_STATUS, 8'h00);
        for (int m = 0; m < 3; m++) begin
            wr_reg(`PCFO_CHMODE_BASE, OFFMODE[m]);
            settle(2);
            e = edges;
            settle(16'h0258);
            `CHK(edges, e)
        end
        wr_reg(`PCFO_CMP0_HI, 8'h04);
        settle(16'h012c);
        `CHK(half, 10'h004)
        wr_reg(`PCFO_CMP0_LO, 8'h10);
        settle(2);
        e = edges;
        settle(16'h003c);
        `CHK(edges, e)
        // counter parked just below a 16-bit match at 0x0108
        wr_reg(`PCFO_CTRMODE, 8'h00);
        wr_reg(`PCFO_CTR_HI, 8'h01);
        wr_reg(`PCFO_CTR_LO, 8'h00);
        wr_reg(`PCFO_CMP0_LO, 8'h08);
        wr_reg(`PCFO_CMP0_HI, 8'h01);
        wr_reg(`PCFO_CHMODE_BASE, 8'h4e);
        wr_reg(`PCFO_CTRMODE, 8'h07);
        settle(20);
        wr_reg(`PCFO_CTRMODE, 8'h00);
        check(`PCFO_IRQ_STATUS, 8'h01);
        `CHK(irq, 1'b0)
        wr_reg(`PCFO_IRQ_MASK, 8'h01);
        settle(2);
        `CHK(irq, 1'b1)
        wr_reg(`PCFO_IRQ_MASK, 8'h00);
        settle(2);
        `CHK(irq, 1'b0)
        wr_reg(`PCFO_IRQ_STATUS, 8'h01);
        wr_reg(`PCFO_IRQ_MASK, 8'h01);
        check(`PCFO_IRQ_STATUS, 8'h00);
        `CHK(irq, 1'b0)
        results();
    end
endmodule
